// *** hw/spce_spi.v ***
// serial peripheral: clocking, select handling, mode fault and write collision
`timescale 1ns/10ps
`default_nettype none
`include "spce_consts.vh"
module spce_spi (
	// clock and reset
	input wire aclk,
	input wire aresetn,
	// axi4-lite write
	input wire [4:0] awaddr,
	input wire awvalid,
	output reg awready,
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// axi4-lite read
	input wire [4:0] araddr,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// serial pins
	input wire sck_in,
	output reg sck_out,
	output reg sck_oe,
	input wire mosi_in,
	output reg mosi_out,
	output reg mosi_oe,
	input wire miso_in,
	output reg miso_out,
	output reg miso_oe,
	input wire ss_n_in,
	output reg ss_n_out,
	output reg ss_n_oe,
	// interrupt and processor mask
	input wire cpu_irq_mask,
	output reg irq
);
	reg [7:0] ctrl;
	reg [7:0] ddr;
	reg [7:0] mask;
	reg [7:0] port_out;
	reg done_f, wcol_f, mode_fault_flag_f;
	reg [7:0] shreg;
	reg [7:0] rxbuf;
	reg busy;
	reg [3:0] bitcnt;
	reg [5:0] divcnt;
	reg phase_hi;
	reg in_bit;
	reg [2:0] sck_s, ss_s;
	reg [1:0] mosi_s, miso_s;
	reg aw_hold, w_hold;
	reg [4:0] aw_addr;
	reg [7:0] w_dat;
	reg [2:0] smp_dly;
	reg [7:0] rx_sh;
	reg [3:0] rx_cnt;
	wire en = ctrl[`SPCE_EN_BIT];
	wire master_select_bit = ctrl[`SPCE_MASTER_SELECT_BIT_BIT];
	wire clock_phase_bit = ctrl[`SPCE_CLOCK_PHASE_BIT_BIT];
	wire clock_polarity_bit = ctrl[`SPCE_CLOCK_POLARITY_BIT_BIT];
	wire [1:0] rate = ctrl[`SPCE_RATE_LSB+1:`SPCE_RATE_LSB];
	wire [7:0] status = {done_f, wcol_f, 1'b0, mode_fault_flag_f, 4'h0};

	// half period in aclk cycles per rate code
	function [5:0] half_div;
		input [1:0] r;
		begin
			case (r)
				2'b00: half_div = `SPCE_HALF_R0;
				2'b01: half_div = `SPCE_HALF_R1;
				2'b10: half_div = `SPCE_HALF_R2;
				default: half_div = `SPCE_HALF_R3;
			endcase
		end
	endfunction

	// legal register word: aligned and inside the map
	function addr_ok;
		input [4:0] a;
		begin
			addr_ok = (a <= `SPCE_PORT_OFF) && (a[1:0] == 2'b00);
		end
	endfunction

	// synchronisers: logic reads only the second stage and later
	always @(posedge aclk) begin
		if (!aresetn) begin
			sck_s <= 3'b000;
			ss_s <= 3'b111;
			mosi_s <= 2'b00;
			miso_s <= 2'b00;
		end else begin
			sck_s <= {sck_s[1:0], sck_in};
			ss_s <= {ss_s[1:0], ss_n_in};
			mosi_s <= {mosi_s[0], mosi_in};
			miso_s <= {miso_s[0], miso_in};
		end
	end
	wire ss_low = ~ss_s[1];
	wire ss_rise = ss_s[1] & ~ss_s[2];
	// slave shift clock is select OR sck under phase 0
	wire sclk_now = clock_phase_bit ? sck_s[1] : (sck_s[1] | ss_s[1]); // see RL8
	wire sclk_prev = clock_phase_bit ? sck_s[2] : (sck_s[2] | ss_s[2]);
	wire s_rise = sclk_now & ~sclk_prev;
	wire s_fall = ~sclk_now & sclk_prev;
	// leading and trailing edges relative to polarity
	wire s_lead = clock_polarity_bit ? s_fall : s_rise; // see RL2
	wire s_trail = clock_polarity_bit ? s_rise : s_fall;
	wire ss_gpio = ddr[`SPCE_SS_DDR_BIT];
	wire mode_fault_flag_ev = en & master_select_bit & ~ss_gpio & ss_low; // see RL5 RL6
	wire wr_go = aw_hold & w_hold & ~bvalid;
	wire data_wr = wr_go & (aw_addr == `SPCE_DATA_OFF);
	wire rd_go = arvalid & ~rvalid;
	wire stat_rd = arvalid & arready & (araddr == `SPCE_STAT_OFF);
	wire m_run = busy & en & master_select_bit & (bitcnt != 4'h0);
	wire m_tick = m_run & (divcnt == 6'h01);
	wire m_sample = m_tick & ~phase_hi;
	wire slave_sel = en & ~master_select_bit & (ss_low | clock_phase_bit);

	// axi write channel capture
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 5'h00;
			w_dat <= 8'h00;
			bvalid <= 1'b0;
			bresp <= 2'b00;
		end else begin
			awready <= ~aw_hold & ~awready & awvalid;
			wready <= ~w_hold & ~wready & wvalid;
			if (awvalid & awready) begin
				aw_hold <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid & wready) begin
				w_hold <= 1'b1;
				w_dat <= wdata[7:0] & {8{wstrb[0]}};
			end
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				bvalid <= 1'b1;
				bresp <= addr_ok(aw_addr) ? 2'b00 : 2'b10;
			end else if (bvalid & bready)
				bvalid <= 1'b0;
		end
	end

	// axi read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= 2'b00;
		end else begin
			arready <= rd_go & ~arready;
			if (rd_go & ~arready) begin
				rvalid <= 1'b0;
			end else if (arvalid & arready) begin
				rvalid <= 1'b1;
				rresp <= 2'b00;
				case (araddr)
					`SPCE_CTRL_OFF: rdata <= {24'h000000, ctrl};
					`SPCE_STAT_OFF: rdata <= {24'h000000, status};
					`SPCE_DATA_OFF: rdata <= {24'h000000, rxbuf};
					`SPCE_DDR_OFF: rdata <= {24'h000000, ddr};
					`SPCE_MASK_OFF: rdata <= {24'h000000, mask};
					default: begin
						rdata <= 32'h00000000;
						rresp <= 2'b10;
					end
				endcase
			end else if (rvalid & rready)
				rvalid <= 1'b0;
		end
	end

	// control registers written over the bus
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `SPCE_CTRL_RST;
			ddr <= `SPCE_DDR_RST;
			mask <= `SPCE_MASK_RST;
			port_out <= `SPCE_PORT_RST;
		end else begin
			if (wr_go) begin
				case (aw_addr)
					`SPCE_CTRL_OFF: ctrl <= w_dat;
					`SPCE_DDR_OFF: ddr <= w_dat;
					`SPCE_MASK_OFF: mask <= w_dat;
					`SPCE_PORT_OFF: port_out <= w_dat;
					default: ;
				endcase
			end
			// a fault drops master and frees the interface pins, over any write
			if (mode_fault_flag_ev) begin
				ctrl[`SPCE_MASTER_SELECT_BIT_BIT] <= 1'b0; // see RL10
				ddr <= ddr & ~`SPCE_DDR_SPI_MASK;
			end
		end
	end

	// miso returns through the clock flop and the synchroniser: sample three cycles late
	always @(posedge aclk) begin
		if (!aresetn)
			smp_dly <= 3'b000;
		else
			smp_dly <= {smp_dly[1:0], m_sample};
	end

	// flags, shifter and both transfer engines
	always @(posedge aclk) begin
		if (!aresetn) begin
			done_f <= 1'b0;
			wcol_f <= 1'b0;
			mode_fault_flag_f <= 1'b0;
			shreg <= 8'h00;
			rxbuf <= 8'h00;
			rx_sh <= 8'h00;
			busy <= 1'b0;
			bitcnt <= 4'h0;
			rx_cnt <= 4'h0;
			divcnt <= 6'h00;
			phase_hi <= 1'b0;
			in_bit <= 1'b0;
		end else begin
			// a status read clears the flags, but an event later in this block wins
			if (stat_rd) begin
				done_f <= 1'b0;
				wcol_f <= 1'b0;
				mode_fault_flag_f <= 1'b0;
			end
			if (data_wr) begin
				if (busy)
					wcol_f <= 1'b1; // see RL12
				else begin
					shreg <= w_dat; // see RL11
					if (en & master_select_bit) begin
						busy <= 1'b1; // see RL13
						bitcnt <= `SPCE_BITS;
						rx_cnt <= `SPCE_BITS;
						divcnt <= half_div(rate); // see RL3
						phase_hi <= 1'b0;
					end
				end
			end
			// master: two half periods per bit, the bit shifts out at the end of the second
			if (m_run) begin // see RL1
				if (m_tick) begin
					divcnt <= half_div(rate);
					phase_hi <= ~phase_hi;
					if (phase_hi) begin
						shreg <= {shreg[6:0], 1'b0};
						bitcnt <= bitcnt - 4'h1;
					end
				end else
					divcnt <= divcnt - 6'h01;
			end
			// master: delayed receive, done once the clock has stopped and eight bits are in
			if (busy & en & master_select_bit & smp_dly[2] & (rx_cnt != 4'h0)) begin
				rx_sh <= {rx_sh[6:0], miso_s[1]};
				rx_cnt <= rx_cnt - 4'h1;
			end
			if (busy & en & master_select_bit & (bitcnt == 4'h0) & (rx_cnt == 4'h0)) begin
				busy <= 1'b0;
				done_f <= 1'b1;
				rxbuf <= rx_sh;
			end
			// slave: clock from the far master, rate field unused
			if (slave_sel) begin
				if (!busy & (s_lead | s_trail)) begin
					busy <= 1'b1;
					bitcnt <= `SPCE_BITS;
				end
				if (s_lead & ~clock_phase_bit)
					in_bit <= mosi_s[1];
				if (s_trail & busy) begin
					shreg <= {shreg[6:0], clock_phase_bit ? mosi_s[1] : in_bit};
					bitcnt <= bitcnt - 4'h1;
					if (bitcnt == 4'h1) begin
						busy <= 1'b0;
						done_f <= 1'b1;
						rxbuf <= {shreg[6:0], clock_phase_bit ? mosi_s[1] : in_bit};
					end
				end
			end else if (en & ~master_select_bit & ss_rise)
				busy <= 1'b0;
			if (mode_fault_flag_ev) begin
				mode_fault_flag_f <= 1'b1; // see RL5
				busy <= 1'b0;
			end
		end
	end

	// serial pins, owned by the interface while enabled
	always @(posedge aclk) begin
		if (!aresetn) begin
			sck_out <= 1'b0;
			sck_oe <= 1'b0;
			mosi_out <= 1'b0;
			mosi_oe <= 1'b0;
			miso_out <= 1'b0;
			miso_oe <= 1'b0;
		end else begin
			sck_out <= clock_polarity_bit ^ (m_run & (phase_hi ^ clock_phase_bit)); // see RL7
			sck_oe <= en & master_select_bit; // see RL1
			mosi_out <= shreg[7];
			mosi_oe <= en & master_select_bit;
			miso_out <= shreg[7];
			miso_oe <= en & ~master_select_bit & ss_low; // see RL4
		end
	end

	// select pin as a general output
	always @(posedge aclk) begin
		if (!aresetn) begin
			ss_n_out <= 1'b1;
			ss_n_oe <= 1'b0;
		end else begin
			ss_n_out <= port_out[`SPCE_SS_DDR_BIT];
			ss_n_oe <= ss_gpio; // see RL6
		end
	end

	// level interrupt from unmasked sticky flags
	always @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= ctrl[`SPCE_IE_BIT] & ~cpu_irq_mask & |(status & mask); // see RL10
	end
endmodule // spce_spi
`default_nettype wire

// *** hw/spce_consts.vh ***
// constants of the serial peripheral block
// What this block does
// RL1 - the master makes the serial clock and one byte is swapped over the two data lines in eight clock cycles.
// RL2 - clock polarity and clock phase bits give four timings, and both ends must use the same one.
// RL3 - the two-bit rate field sets the clock rate as master and does nothing as slave.
// RL4 - the far party drives a slave's low-active select low before a transfer and holds it low throughout.
// RL5 - as master the select input must stay high, and a low level sets the mode fault flag.
// RL6 - direction bit 5 set makes the select pin a general output and blocks mode fault detection.
// RL7 - while enabled, the clock and both data lines belong to the interface whatever the port settings.
// RL8 - with phase 0 the slave shift clock is select OR serial clock, so select goes high between bytes.
// RL9 - with phase 1 select may stay low between bytes and a sole slave may tie it low.
// RL10 - a mode fault clears the master bit and the four interface direction bits and raises a gated interrupt.
// RL11 - data is not double buffered, so a write while idle loads the shift register directly.
// RL12 - a write during a transfer flags a write collision, the transfer goes on and the data is dropped.
// RL13 - as master a write while idle starts eight clock cycles at the selected rate.
`ifndef SPCE_CONSTS_VH
`define SPCE_CONSTS_VH
`define SPCE_CTRL_OFF 5'h00
`define SPCE_STAT_OFF 5'h04
`define SPCE_DATA_OFF 5'h08
`define SPCE_DDR_OFF 5'h0C
`define SPCE_MASK_OFF 5'h10
`define SPCE_PORT_OFF 5'h14
`define SPCE_RATE_LSB 0
`define SPCE_CLOCK_PHASE_BIT_BIT 2
`define SPCE_CLOCK_POLARITY_BIT_BIT 3
`define SPCE_MASTER_SELECT_BIT_BIT 4
`define SPCE_EN_BIT 6
`define SPCE_IE_BIT 7
`define SPCE_DONE_BIT 7
`define SPCE_WCOL_BIT 6
`define SPCE_MODE_FAULT_FLAG_BIT 4
`define SPCE_SS_DDR_BIT 5
`define SPCE_DDR_SPI_MASK 8'h3C
`define SPCE_CTRL_RST 8'h04
`define SPCE_DDR_RST 8'h00
`define SPCE_MASK_RST 8'h00
`define SPCE_PORT_RST 8'hFF
`define SPCE_HALF_R0 6'h01
`define SPCE_HALF_R1 6'h02
`define SPCE_HALF_R2 6'h08
`define SPCE_HALF_R3 6'h10
`define SPCE_BITS 4'h8
`endif

// *** bench/spce_spi_sva.sv ***
// port assertions for the serial block
`timescale 1ns/10ps
`default_nettype none
module spce_spi_sva (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// watched ports
	input wire logic wvalid,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic sck_oe,
	input wire logic mosi_oe,
	input wire logic miso_oe,
	input wire logic ss_n_in,
	input wire logic ss_n_oe,
	input wire logic cpu_irq_mask,
	input wire logic irq
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	irq_gate_a: assert property (cpu_irq_mask |=> !irq)
		else $error("irq masked");
	mode_fault_flag_drop_a: assert property ((sck_oe && !ss_n_oe && !ss_n_in)[*4] |-> ##[0:4] !sck_oe)
		else $error("no fault");
	mode_fault_flag_off_a: assert property ((sck_oe && ss_n_oe && !wvalid)[*5] |=> sck_oe)
		else $error("fault");
	pin_own_a: assert property (sck_oe |-> mosi_oe)
		else $error("mosi");
	clk_role_a: assert property (miso_oe |-> !sck_oe)
		else $error("role");
	sel_gate_a: assert property (ss_n_in[*5] |-> !miso_oe)
		else $error("miso");
	rd_zero_a: assert property (rvalid && rresp != 2'h0 |-> rdata == 32'h0)
		else $error("rdata");
	rd_byte_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("rdata hi");
endmodule // spce_spi_sva
bind spce_spi spce_spi_sva i_spce_spi_sva (.aclk, .aresetn, .wvalid, .rdata, .rresp, .rvalid,
	.sck_oe, .mosi_oe, .miso_oe, .ss_n_in, .ss_n_oe, .cpu_irq_mask, .irq);
`default_nettype wire

// *** bench/spce_slave_model.sv ***
// far-side slave on the serial pins
`timescale 1ns/10ps
`default_nettype none
module spce_slave_model (
	// serial pins
	input wire logic sck,
	input wire logic mosi,
	output logic miso,
	// setup
	input wire logic clock_polarity_bit,
	input wire logic clock_phase_bit,
	input wire logic arm,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte
);
	int k = 8;
	initial miso = 1'b0;
	always @(posedge arm) begin
		k = 0;
		miso = clock_phase_bit ? ~miso : tx_byte[7];
	end
	always @(sck) begin
		if (k < 8 && (sck ^ clock_polarity_bit)) begin
			if (clock_phase_bit) miso = tx_byte[7 - k];
			else rx_byte = {rx_byte[6:0], mosi};
		end else if (k < 8) begin
			if (clock_phase_bit) rx_byte = {rx_byte[6:0], mosi};
			k++;
			miso = (k < 8 && !clock_phase_bit) ? tx_byte[7 - k] : ~miso;
		end
	end
endmodule // spce_slave_model
`default_nettype wire

// *** bench/spce_spi_tb.sv ***
// self-checking bench for the serial block
`timescale 1ns/10ps
`default_nettype none
module spce_spi_tb;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, ss_drv = 1'b1, cpu_irq_mask = 1'b0;
	logic clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, arm = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, sck_out, sck_oe, mosi_out, mosi_oe;
	logic miso_oe, ss_n_out, ss_n_oe, miso;
	logic [1:0] bresp, rresp;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [3:0] wstrb = 4'h1;
	logic [7:0] tx = 8'h00, rx, st;
	wire sck_pin = sck_oe ? sck_out : clock_polarity_bit;
	wire ss_pin = ss_n_oe ? ss_n_out : ss_drv;
	int errors = 0, tests_run = 0, edges = 0, t0 = 0, t1 = 0;
	int half[4] = '{1, 2, 8, 16};
	spce_spi i_spce_spi (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .sck_in(sck_pin), .sck_out, .sck_oe, .mosi_in(mosi_out), .mosi_out,
		.mosi_oe, .miso_in(miso), .miso_out(), .miso_oe, .ss_n_in(ss_pin), .ss_n_out,
		.ss_n_oe, .cpu_irq_mask, .irq
	);
	spce_slave_model i_spce_slave_model (.sck(sck_pin), .mosi(mosi_out), .miso, .clock_polarity_bit,
		.clock_phase_bit, .arm, .tx_byte(tx), .rx_byte(rx));
	initial forever #20 aclk = ~aclk;
	always @(sck_out) begin
		edges++;
		if (edges == 1) t0 = int'($time);
		t1 = int'($time);
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		n = 0;
		awaddr <= a;
		araddr <= a;
		wdata <= {24'h0, d};
		awvalid <= w;
		wvalid <= w;
		arvalid <= !w;
		bready <= w;
		rready <= !w;
		while ((w ? bvalid : rvalid) !== 1'b1 && n < 50) begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		rv = rdata;
		bready <= 1'b0;
		rready <= 1'b0;
		if (n == 50) begin
			errors++;
			print_verdict();
		end
		@(posedge aclk);
	endtask
	task automatic poll();
		st = 8'h00;
		for (int n = 0; n < 200 && !st[7]; n++) begin
			acc(1'b0, 5'h04, 8'h00);
			st = st | rv[7:0];
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		acc(1'b0, 5'h00, 8'h00);
		chk(rv, 32'h04);
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, 5'h00, 8'h50 | 8'(i * 5));
			acc(1'b1, 5'h0C, 8'h1C);
			clock_polarity_bit <= i[1];
			clock_phase_bit <= i[0];
			tx <= 8'hC3 ^ 8'(i);
			arm <= 1'b1;
			edges = 0;
			acc(1'b1, 5'h08, 8'h5A + 8'(i));
			arm <= 1'b0;
			poll();
			chk(edges, 16);
			chk(t1 - t0, 600 * half[i]);
			chk(32'(st), 32'h80);
			chk(32'(rx), 32'(8'h5A + 8'(i)));
			acc(1'b0, 5'h08, 8'h00);
			chk(rv, 32'(tx));
		end
		arm <= 1'b1;
		acc(1'b1, 5'h08, 8'h3E);
		arm <= 1'b0;
		acc(1'b1, 5'h08, 8'hFF);
		poll();
		chk(32'(st), 32'hC0);
		chk(32'(rx), 32'h3E);
		acc(1'b1, 5'h10, 8'h10);
		acc(1'b1, 5'h00, 8'hD0);
		cpu_irq_mask <= 1'b1;
		ss_drv <= 1'b0;
		for (int n = 0; n < 50 && sck_oe !== 1'b0; n++) @(posedge aclk);
		chk(32'(sck_oe), 32'h0);
		chk(32'(irq), 32'h0);
		cpu_irq_mask <= 1'b0;
		for (int n = 0; n < 50 && irq !== 1'b1; n++) @(posedge aclk);
		chk(32'(irq), 32'h1);
		acc(1'b0, 5'h00, 8'h00);
		chk(rv, 32'hC0);
		acc(1'b0, 5'h0C, 8'h00);
		chk(rv, 32'h00);
		acc(1'b0, 5'h04, 8'h00);
		chk(rv, 32'h10);
		for (int n = 0; n < 50 && irq !== 1'b0; n++) @(posedge aclk);
		chk(32'(irq), 32'h0);
		acc(1'b1, 5'h0C, 8'h3C);
		acc(1'b1, 5'h14, 8'h00);
		acc(1'b1, 5'h00, 8'h50);
		acc(1'b0, 5'h04, 8'h00);
		chk(rv, 32'h00);
		chk(32'(sck_oe), 32'h1);
		acc(1'b0, 5'h18, 8'h00);
		chk(32'(rresp), 32'h2);
		print_verdict();
	end
endmodule // spce_spi_tb
`default_nettype wire
